/* rtl/mmst_pkg.sv */
// constants, types and helpers for the attachment management block
package mmst_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_FREQ_KHZ   = 100000;
  localparam int unsigned RESET_HOLD_MS  = 500;
  localparam int unsigned FC_GAP_MS      = 100;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * CLK_FREQ_KHZ;
  localparam int unsigned FC_GAP_CYC     = FC_GAP_MS * CLK_FREQ_KHZ;
  localparam int unsigned FREQ_UNIT_KHZ  = 250;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_ADMIN   = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_LOSS    = 8'h0c;
  localparam logic [7:0] ADDR_JABBER  = 8'h10;
  localparam logic [7:0] ADDR_FALSE   = 8'h14;
  localparam logic [7:0] ADDR_BBAND   = 8'h18;
  localparam logic [7:0] ADDR_ABILITY = 8'h1c;

  // ==========================================================
  // field positions and reset values
  localparam int CTL_TYPE_LSB  = 0;
  localparam int CTL_ANEG_BIT  = 8;
  localparam int CTL_RESET_BIT = 16;
  localparam int ST_MEDIA_LSB  = 0;
  localparam int ST_JABBER_LSB = 8;
  localparam int ST_ADMIN_LSB  = 16;
  localparam int BB_OFFS_LSB   = 16;
  localparam int AB_SPLIT_LSB  = 16;
  localparam logic        CTL_ANEG_RST  = 1'b1;
  localparam logic [15:0] TYPE_ABIL_DEF = 16'h3ffc;

  // ==========================================================
  // enumerations
  typedef enum logic [3:0] {
    AT_OTHER, AT_UNKNOWN, AT_AUI, AT_THICK, AT_FOIRL, AT_THIN,
    AT_BROAD, AT_TWIST, AT_FPASS, AT_FSYNC, AT_FASYNC, AT_T4,
    AT_TX, AT_FX
  } mmst_type_t;

  typedef enum logic [3:0] {
    MA_OTHER, MA_UNKNOWN, MA_AVAIL, MA_NOT_AVAIL, MA_RFAULT,
    MA_INVALID, MA_RJABBER, MA_RLINK, MA_RTEST
  } mmst_media_t;

  typedef enum logic [1:0] {
    JF_OTHER, JF_UNKNOWN, JF_NORMAL, JF_FAULT
  } mmst_jabber_t;

  typedef enum logic [2:0] {
    AD_OTHER, AD_UNKNOWN, AD_OPER, AD_STANDBY, AD_SHUTDOWN
  } mmst_admin_t;

  typedef enum logic [1:0] {SK_OTHER, SK_SINGLE, SK_DUAL} mmst_split_t;

  typedef enum logic [1:0] {
    RR_NONE, RR_JABBER, RR_LINK, RR_TEST
  } mmst_reason_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic         link_fail;
    logic         rx_active;
    logic         tx_active;
    logic         collision;
    logic         mii_link;
    logic         mii_rfault;
    mmst_reason_t rf_reason;
    logic         integ_ok;
    logic         jabber;
    logic         false_carrier;
    logic         carrier_valid;
    logic [15:0]  abilities;
  } mmst_pins_t;

  typedef struct packed {
    logic rx_pass;
    logic coll_pass;
    logic tx_pass;
    logic power_on;
    logic reset_busy;
  } mmst_attach_t;

  // ==========================================================
  // type classes
  function automatic logic is_link(mmst_type_t t);
    return t inside {AT_FOIRL, AT_TWIST, AT_FSYNC, AT_FASYNC};
  endfunction

  function automatic logic is_loop(mmst_type_t t);
    return t inside {AT_AUI, AT_THICK, AT_THIN, AT_BROAD, AT_FPASS};
  endfunction

  function automatic logic is_fast(mmst_type_t t);
    return t inside {AT_T4, AT_TX, AT_FX};
  endfunction

  function automatic logic is_mixing(mmst_type_t t);
    return t inside {AT_AUI, AT_THICK, AT_THIN, AT_BROAD};
  endfunction

  function automatic mmst_media_t remote_value(mmst_reason_t r);
    case (r)
      RR_JABBER: return MA_RJABBER;
      RR_LINK:   return MA_RLINK;
      RR_TEST:   return MA_RTEST;
      default:   return MA_RFAULT;
    endcase
  endfunction

endpackage

/* rtl/mmst_event_counter.sv */
// free-running wrapping event counter
`timescale 1ns/1ps
module mmst_event_counter #(
  parameter int unsigned WIDTH = 32
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // event
  input  wire logic             i_inc,
  // count
  output logic [WIDTH-1:0]      o_count
);

  // ==========================================================
  // counter
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_count <= '0;
    end else if (i_inc) begin
      o_count <= o_count + 1'b1;
    end
  end

endmodule

/* rtl/mmst_mau_status.sv */
// management status, counters and control of the attachment unit
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module mmst_mau_status
  import mmst_pkg::*;
#(
  parameter int unsigned RESET_HOLD_CYCLES = RESET_HOLD_CYC,
  parameter int unsigned FC_GAP_CYCLES     = FC_GAP_CYC,
  parameter int unsigned CNT_WIDTH         = 32,
  parameter int unsigned TX_CARRIER_KHZ    = 0,
  parameter int unsigned OFFSET_KHZ        = 0,
  parameter mmst_split_t SPLIT_KIND        = SK_OTHER,
  parameter logic        AUTONEG_PRESENT   = 1'b1,
  parameter logic [15:0] TYPE_ABILITIES    = TYPE_ABIL_DEF
) (
  // clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // attachment circuits
  input  wire mmst_pins_t  I_PINS,
  output mmst_attach_t     O_ATTACH,
  output mmst_type_t       O_ATTACH_TYPE,
  output logic             O_FORCE_MODE,
  output logic             O_AUTONEG_EN,
  output logic             O_JABBER_NOTIFY
);

  // ==========================================================
  // declarations
  localparam logic [15:0] TX_CODE =
    16'(TX_CARRIER_KHZ / FREQ_UNIT_KHZ);
  localparam logic [15:0] OFFS_CODE = 16'(OFFSET_KHZ / FREQ_UNIT_KHZ);

  mmst_pins_t             pins_meta_reg;
  mmst_pins_t             pins_reg;
  mmst_pins_t             prev_reg;
  mmst_type_t             type_reg;
  logic                   aneg_reg;
  mmst_admin_t            admin_reg;
  mmst_admin_t            admin_next;
  mmst_media_t            media_reg;
  mmst_media_t            media_next;
  mmst_jabber_t           jab_reg;
  mmst_jabber_t           jab_next;
  logic [31:0]            hold_reg;
  logic [31:0]            fc_gap_reg;
  logic                   coll_seen_reg;
  logic [31:0]            prdata_reg;
  logic                   err_reg;
  logic                   notify_reg;
  mmst_attach_t           attach_reg;
  logic [CNT_WIDTH-1:0]   loss_count;
  logic [CNT_WIDTH-1:0]   jab_count;
  logic [CNT_WIDTH-1:0]   fc_count;
  logic [31:0]            rd_data;
  logic [15:0]            abil;
  logic                   wr;
  logic                   wr_ctl;
  logic                   wr_adm;
  logic                   type_ok;
  logic                   hold_busy;
  logic                   tx_end;
  logic                   clean_end;
  logic                   fc_inc;
  logic                   loss_inc;
  logic                   jab_inc;
  logic                   mapped;

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      pins_meta_reg <= '0;
      pins_reg      <= '0;
      prev_reg      <= '0;
    end else begin
      pins_meta_reg <= I_PINS;
      pins_reg      <= pins_meta_reg;
      prev_reg      <= pins_reg;
    end
  end

  // ==========================================================
  // apb decode
  assign wr      = I_PSEL & I_PENABLE & I_PWRITE;
  assign wr_ctl  = wr & (I_PADDR == ADDR_CONTROL);
  assign wr_adm  = wr & (I_PADDR == ADDR_ADMIN);
  assign mapped  = I_PADDR inside {ADDR_CONTROL, ADDR_ADMIN, ADDR_STATUS,
                                   ADDR_LOSS, ADDR_JABBER, ADDR_FALSE,
                                   ADDR_BBAND, ADDR_ABILITY};
  assign abil    = AUTONEG_PRESENT ? pins_reg.abilities
                                   : TYPE_ABILITIES;
  assign type_ok = (I_PWDATA[CTL_TYPE_LSB+:4] <= 4'(AT_FX)) &&
                   abil[I_PWDATA[CTL_TYPE_LSB+:4]];
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & err_reg;
  assign O_PRDATA  = prdata_reg;

  always_comb begin
    rd_data = 32'h0;
    case (I_PADDR)
      ADDR_CONTROL: begin
        rd_data[CTL_TYPE_LSB+:4] = type_reg;
        rd_data[CTL_ANEG_BIT]    = aneg_reg;
        rd_data[CTL_RESET_BIT]   = hold_busy;
      end
      ADDR_ADMIN:   rd_data[2:0] = admin_reg;
      ADDR_STATUS: begin
        rd_data[ST_MEDIA_LSB+:4]  = media_reg;
        rd_data[ST_JABBER_LSB+:2] = jab_reg;
        rd_data[ST_ADMIN_LSB+:3]  = admin_reg;
      end
      ADDR_LOSS:    rd_data = 32'(loss_count);
      ADDR_JABBER:  rd_data = 32'(jab_count);
      ADDR_FALSE:   rd_data = 32'(fc_count);
      ADDR_BBAND: begin
        if (type_reg == AT_BROAD) begin
          rd_data = {OFFS_CODE, TX_CODE};
        end
      end
      ADDR_ABILITY: begin
        rd_data[15:0] = abil;
        rd_data[AB_SPLIT_LSB+:2] =
          (type_reg == AT_BROAD) ? SPLIT_KIND : SK_OTHER;
      end
      default:      rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      prdata_reg <= 32'h0;
      err_reg    <= 1'b0;
    end else if (I_PSEL & ~I_PENABLE) begin
      prdata_reg <= I_PWRITE ? 32'h0 : rd_data;
      err_reg    <= ~mapped;
    end
  end

  // ==========================================================
  // type and negotiation control
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      type_reg <= AT_UNKNOWN;
      aneg_reg <= CTL_ANEG_RST;
    end else if (wr_ctl) begin
      aneg_reg <= I_PWDATA[CTL_ANEG_BIT];
      if (type_ok) begin
        type_reg <= mmst_type_t'(I_PWDATA[CTL_TYPE_LSB+:4]);
      end
    end
  end

  assign O_ATTACH_TYPE = type_reg;
  assign O_AUTONEG_EN  = aneg_reg;
  assign O_FORCE_MODE  = ~aneg_reg;

  // ==========================================================
  // reset action timer
  assign hold_busy = (hold_reg != 32'h0);

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      hold_reg <= 32'h0;
    end else if (wr_ctl & I_PWDATA[CTL_RESET_BIT]) begin
      hold_reg <= RESET_HOLD_CYCLES;
    end else if (hold_busy) begin
      hold_reg <= hold_reg - 32'h1;
    end
  end

  // ==========================================================
  // administrative state
  always_comb begin
    admin_next = admin_reg;
    if (hold_busy) begin
      admin_next = AD_OPER;
    end else if (wr_adm) begin
      case (mmst_admin_t'(I_PWDATA[2:0]))
        AD_OPER:     admin_next = AD_OPER;
        AD_SHUTDOWN: admin_next = AD_SHUTDOWN;
        AD_STANDBY: begin
          if (is_mixing(type_reg)) begin
            admin_next = AD_SHUTDOWN;
          end else if (is_link(type_reg)) begin
            admin_next = AD_STANDBY;
          end
        end
        default:     admin_next = admin_reg;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      admin_reg <= AD_OPER;
    end else begin
      admin_reg <= admin_next;
    end
  end

  // ==========================================================
  // attachment circuit gating
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      attach_reg <= '0;
    end else begin
      attach_reg.rx_pass    <= (admin_reg == AD_OPER) & ~hold_busy;
      attach_reg.coll_pass  <= (admin_reg == AD_OPER) & ~hold_busy;
      attach_reg.tx_pass    <= (admin_reg == AD_OPER) & ~hold_busy;
      attach_reg.power_on   <= ~((admin_reg == AD_SHUTDOWN) &
                                 (type_reg == AT_AUI));
      attach_reg.reset_busy <= hold_busy;
    end
  end

  assign O_ATTACH = attach_reg;

  // ==========================================================
  // loopback test on transmissions
  assign tx_end    = prev_reg.tx_active & ~pins_reg.tx_active;
  assign clean_end = tx_end & ~coll_seen_reg & ~pins_reg.collision;

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      coll_seen_reg <= 1'b0;
    end else if (pins_reg.tx_active & ~prev_reg.tx_active) begin
      coll_seen_reg <= pins_reg.collision;
    end else if (pins_reg.tx_active & pins_reg.collision) begin
      coll_seen_reg <= 1'b1;
    end
  end

  // ==========================================================
  // media availability
  always_comb begin
    media_next = media_reg;
    if (admin_reg == AD_SHUTDOWN) begin
      media_next = MA_OTHER;
    end else if (hold_busy) begin
      media_next = MA_UNKNOWN;
    end else if (is_fast(type_reg)) begin
      if (~pins_reg.mii_link | ~pins_reg.integ_ok) begin
        media_next = MA_NOT_AVAIL;
      end else if (pins_reg.mii_rfault) begin
        media_next = remote_value(pins_reg.rf_reason);
      end else begin
        media_next = MA_AVAIL;
      end
    end else if (is_link(type_reg)) begin
      if (pins_reg.link_fail | ~pins_reg.mii_link) begin
        media_next = MA_NOT_AVAIL;
      end else if (pins_reg.mii_rfault) begin
        media_next = remote_value(pins_reg.rf_reason);
      end else begin
        media_next = MA_AVAIL;
      end
    end else if (is_loop(type_reg)) begin
      if (clean_end) begin
        media_next = pins_reg.rx_active ? MA_AVAIL
                                        : MA_NOT_AVAIL;
      end
    end else begin
      media_next = MA_UNKNOWN;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      media_reg <= MA_UNKNOWN;
    end else if (wr_ctl & type_ok) begin
      media_reg <= MA_UNKNOWN;
    end else begin
      media_reg <= media_next;
    end
  end

  assign loss_inc = (media_reg == MA_AVAIL) &
                    ((media_next != MA_AVAIL) |
                     (wr_ctl & type_ok));

  // ==========================================================
  // jabber flag and notification
  always_comb begin
    if (admin_reg == AD_SHUTDOWN) begin
      jab_next = JF_OTHER;
    end else if (hold_busy) begin
      jab_next = JF_UNKNOWN;
    end else if (type_reg == AT_AUI) begin
      jab_next = JF_OTHER;
    end else if (is_fast(type_reg)) begin
      jab_next = JF_NORMAL;
    end else begin
      jab_next = pins_reg.jabber ? JF_FAULT : JF_NORMAL;
    end
  end

  assign jab_inc = (jab_next == JF_FAULT) &
                   (jab_reg != JF_FAULT);

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      jab_reg    <= JF_UNKNOWN;
      notify_reg <= 1'b0;
    end else begin
      jab_reg    <= jab_next;
      notify_reg <= jab_inc;
    end
  end

  assign O_JABBER_NOTIFY = notify_reg;

  // ==========================================================
  // false carrier rate limit
  assign fc_inc = (type_reg inside {AT_TX, AT_FX}) & ~hold_busy &
                  pins_reg.false_carrier & ~prev_reg.false_carrier &
                  ~pins_reg.carrier_valid &
                  (fc_gap_reg == 32'h0);

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      fc_gap_reg <= 32'h0;
    end else if (pins_reg.carrier_valid) begin
      fc_gap_reg <= 32'h0;
    end else if (fc_inc) begin
      fc_gap_reg <= FC_GAP_CYCLES;
    end else if (fc_gap_reg != 32'h0) begin
      fc_gap_reg <= fc_gap_reg - 32'h1;
    end
  end

  // ==========================================================
  // event counters
  mmst_event_counter #(.WIDTH(CNT_WIDTH)) u_loss_cnt (
    .i_clock (I_CLOCK),
    .i_rst   (I_RST),
    .i_inc   (loss_inc),
    .o_count (loss_count)
  );

  mmst_event_counter #(.WIDTH(CNT_WIDTH)) u_jab_cnt (
    .i_clock (I_CLOCK),
    .i_rst   (I_RST),
    .i_inc   (jab_inc),
    .o_count (jab_count)
  );

  mmst_event_counter #(.WIDTH(CNT_WIDTH)) u_fc_cnt (
    .i_clock (I_CLOCK),
    .i_rst   (I_RST),
    .i_inc   (fc_inc),
    .o_count (fc_count)
  );

  // ==========================================================
  // assertions
  a_reset_unknown: assert property (
    @(posedge I_CLOCK) I_RST |=> media_reg == MA_UNKNOWN)
    else $error("media not unknown after reset");

  a_link_fail_na: assert property (
    @(posedge I_CLOCK) disable iff (I_RST)
    is_link(type_reg) && admin_reg == AD_OPER && !hold_busy &&
    !wr_ctl && pins_reg.link_fail |=> media_reg == MA_NOT_AVAIL)
    else $error("link fail not reported");

  a_na_precedes: assert property (
    @(posedge I_CLOCK) disable iff (I_RST)
    (is_fast(type_reg) || is_link(type_reg)) &&
    admin_reg == AD_OPER && !hold_busy &&
    !wr_ctl && !pins_reg.mii_link && pins_reg.mii_rfault
    |=> media_reg == MA_NOT_AVAIL)
    else $error("remote fault overrode link loss");

  a_loop_hold: assert property (
    @(posedge I_CLOCK) disable iff (I_RST)
    is_loop(type_reg) && admin_reg == AD_OPER && !hold_busy &&
    !wr_ctl && !clean_end |=> $stable(media_reg))
    else $error("loopback media changed without clean transmit");

  a_loss_count: assert property (
    @(posedge I_CLOCK) disable iff (I_RST)
    media_reg == MA_AVAIL ##1 media_reg != MA_AVAIL
    |-> loss_count == $past(loss_count) + 1'b1)
    else $error("media loss not counted");

  a_jab_notify: assert property (
    @(posedge I_CLOCK) disable iff (I_RST)
    jab_next == JF_FAULT && jab_reg != JF_FAULT
    |=> O_JABBER_NOTIFY && jab_count == $past(jab_count) + 1'b1
    ##1 !O_JABBER_NOTIFY)
    else $error("jabber entry not notified or counted");

  a_fast_nojab: assert property (
    @(posedge I_CLOCK) disable iff (I_RST)
    is_fast(type_reg) && $stable(type_reg) |-> jab_reg != JF_FAULT)
    else $error("fast type reported jabber");

  a_standby_idle: assert property (
    @(posedge I_CLOCK) disable iff (I_RST)
    admin_reg == AD_STANDBY |=> !O_ATTACH.rx_pass &&
    !O_ATTACH.coll_pass && !O_ATTACH.tx_pass)
    else $error("standby did not idle circuits");

  a_standby_mix: assert property (
    @(posedge I_CLOCK) disable iff (I_RST)
    wr_adm && !hold_busy && I_PWDATA[2:0] == 3'(AD_STANDBY) &&
    is_mixing(type_reg) |=> admin_reg == AD_SHUTDOWN)
    else $error("standby to mixing type not shut down");

  a_reset_hold: assert property (
    @(posedge I_CLOCK) disable iff (I_RST)
    wr_ctl && I_PWDATA[CTL_RESET_BIT] |=> hold_busy ##1
    O_ATTACH.reset_busy && !O_ATTACH.tx_pass && !O_ATTACH.rx_pass)
    else $error("reset request did not hold circuits idle");

  a_fc_spacing: assert property (
    @(posedge I_CLOCK) disable iff (I_RST)
    fc_inc |=> !fc_inc && (fc_gap_reg == FC_GAP_CYCLES ||
                           pins_reg.carrier_valid))
    else $error("false carrier rate limit broken");

endmodule

/* verification/mmst_partner.sv */
// model of the attachment circuits driving the status pins
`timescale 1ns/1ps
module mmst_partner
  import mmst_pkg::*;
(
  // clock
  input  wire logic i_clock,
  // pins toward the block
  output mmst_pins_t o_pins
);
  // ==========================================================
  // idle levels: link good, no activity, types AT_AUI to AT_FX able
  initial begin
    o_pins = '0;
    o_pins.mii_link = 1'b1;
    o_pins.integ_ok = 1'b1;
    o_pins.abilities = 16'h3ffc;
  end

  // ==========================================================
  // one transmission, echoed on receive when loop is set
  task automatic frame(input logic loop, input logic coll);
    @(posedge i_clock) o_pins.tx_active <= 1'b1;
    repeat (4) @(posedge i_clock);
    o_pins.collision <= coll;
    o_pins.rx_active <= loop;
    @(posedge i_clock) o_pins.collision <= 1'b0;
    @(posedge i_clock) o_pins.tx_active <= 1'b0;
    repeat (3) @(posedge i_clock);
    o_pins.rx_active <= 1'b0;
    repeat (4) @(posedge i_clock);
  endtask
endmodule

/* verification/mmst_mau_status_tb.sv */
// self-checking bench for the attachment management block
`timescale 1ns/1ps
module mmst_mau_status_tb;
  import mmst_pkg::*;
  logic         clk, rst, ps, pe, pw, serr, rdy, slverr, fmode, aen, jn;
  logic [7:0]   pa;
  logic [31:0]  pd, rdata, prdata;
  int           fails, checked, cyc, notes;
  mmst_pins_t   pins;
  mmst_attach_t att;
  mmst_type_t   atype;

  // ==========================================================
  // design and far side
  mmst_mau_status #(.RESET_HOLD_CYCLES(20), .FC_GAP_CYCLES(16),
    .TX_CARRIER_KHZ(1000), .OFFSET_KHZ(500), .SPLIT_KIND(SK_DUAL)) DUT (
    .I_CLOCK(clk), .I_RST(rst), .I_PSEL(ps), .I_PENABLE(pe),
    .I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(pd), .O_PRDATA(prdata),
    .O_PREADY(rdy), .O_PSLVERR(slverr), .I_PINS(pins), .O_ATTACH(att),
    .O_ATTACH_TYPE(atype), .O_FORCE_MODE(fmode), .O_AUTONEG_EN(aen),
    .O_JABBER_NOTIFY(jn));
  mmst_partner P (.i_clock(clk), .o_pins(pins));

  // ==========================================================
  // clock, timeout and notification count
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (jn === 1'b1) notes++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  // ==========================================================
  // bus and compare tasks
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic wr_, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    ps <= 1; pe <= 0; pw <= wr_; pa <= a; pd <= d;
    @(posedge clk);
    pe <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    rdata = prdata;
    serr = slverr;
    ps <= 0;
    pe <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    w(4);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp(rdata, e);
  endtask
  task automatic fc_pulse();
    P.o_pins.false_carrier <= 1'b1;
    w(3);
    P.o_pins.false_carrier <= 1'b0;
    w(3);
  endtask
  task print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial begin
    rst = 1; ps = 0; pe = 0; pw = 0; pa = 8'h00; pd = 32'h0;
    w(4);
    rst <= 0;
    rd(ADDR_STATUS, 32'h00020201);
    rd(ADDR_CONTROL, 32'h00000101);
    rd(8'h20, 32'h0);
    cmp(serr, 1'b1);
    rd(ADDR_LOSS, 32'h0);
    wr(ADDR_CONTROL, 32'h00000102);
    P.frame(1'b1, 1'b0);
    rd(ADDR_STATUS, 32'h00020002);
    P.frame(1'b0, 1'b1);
    rd(ADDR_STATUS, 32'h00020002);
    P.frame(1'b0, 1'b0);
    rd(ADDR_STATUS, 32'h00020003);
    rd(ADDR_LOSS, 32'h1);
    wr(ADDR_CONTROL, 32'h00000107);
    rd(ADDR_STATUS, 32'h00020202);
    P.o_pins.link_fail <= 1'b1;
    w(5);
    rd(ADDR_STATUS, 32'h00020203);
    rd(ADDR_LOSS, 32'h2);
    P.o_pins.link_fail <= 1'b0;
    P.o_pins.mii_rfault <= 1'b1;
    P.o_pins.rf_reason <= RR_JABBER;
    w(5);
    rd(ADDR_STATUS, 32'h00020206);
    P.o_pins.rf_reason <= RR_NONE;
    w(5);
    rd(ADDR_STATUS, 32'h00020204);
    P.o_pins.mii_link <= 1'b0;
    w(5);
    rd(ADDR_STATUS, 32'h00020203);
    P.o_pins.mii_link <= 1'b1;
    P.o_pins.mii_rfault <= 1'b0;
    P.o_pins.jabber <= 1'b1;
    w(5);
    rd(ADDR_STATUS, 32'h00020302);
    rd(ADDR_JABBER, 32'h1);
    cmp(notes, 1);
    P.o_pins.jabber <= 1'b0;
    wr(ADDR_ADMIN, 32'h3);
    cmp({att.rx_pass, att.coll_pass, att.tx_pass}, 3'b000);
    rd(ADDR_STATUS, 32'h00030202);
    wr(ADDR_ADMIN, 32'h2);
    wr(ADDR_CONTROL, 32'h00000102);
    rd(ADDR_LOSS, 32'h3);
    wr(ADDR_ADMIN, 32'h3);
    rd(ADDR_ADMIN, 32'h4);
    cmp(att, 5'b00000);
    rd(ADDR_STATUS, 32'h00040000);
    wr(ADDR_ADMIN, 32'h2);
    wr(ADDR_CONTROL, 32'h00000106);
    rd(ADDR_BBAND, 32'h00020004);
    rd(ADDR_ABILITY, 32'h00023ffc);
    wr(ADDR_CONTROL, 32'h0000010e);
    rd(ADDR_CONTROL, 32'h00000106);
    wr(ADDR_CONTROL, 32'h0000000c);
    cmp({fmode, aen, atype}, {1'b1, 1'b0, AT_TX});
    rd(ADDR_STATUS, 32'h00020202);
    P.o_pins.integ_ok <= 1'b0;
    w(5);
    rd(ADDR_STATUS, 32'h00020203);
    P.o_pins.jabber <= 1'b1;
    w(5);
    P.o_pins.jabber <= 1'b0;
    rd(ADDR_JABBER, 32'h1);
    fc_pulse();
    fc_pulse();
    rd(ADDR_FALSE, 32'h1);
    P.o_pins.carrier_valid <= 1'b1;
    fc_pulse();
    P.o_pins.carrier_valid <= 1'b0;
    w(4);
    fc_pulse();
    rd(ADDR_FALSE, 32'h2);
    xfer(1'b1, ADDR_CONTROL, 32'h0001010c);
    w(2);
    cmp(att, 5'b00011);
    w(30);
    xfer(1'b0, ADDR_CONTROL, 32'h0);
    cmp(rdata[16], 1'b0);
    print_verdict();
  end
endmodule
